// file: src/rswc_cfg.svh
// Constants for the reset, sleep and wake-up sequencer: offsets, fields, reset values, timing
`ifndef RSWC_CFG_SVH
`define RSWC_CFG_SVH
// Register byte offsets on the APB
`define RSWC_A_PC 8'h00
`define RSWC_A_STATUS 8'h04
`define RSWC_A_BANK 8'h08
`define RSWC_A_CONTROL_CONFIG_REGISTER 8'h0C
`define RSWC_A_WMASK 8'h10
`define RSWC_A_CTL 8'h14
`define RSWC_A_IFLAG 8'h18
`define RSWC_A_IMASK 8'h1C
`define RSWC_A_DIR 8'h20
`define RSWC_A_CMD 8'h24
`define RSWC_A_STATE 8'h28
// Field positions
`define RSWC_ST_T 4
`define RSWC_ST_P 3
`define RSWC_CTL_WUE7 0
`define RSWC_CTL_OSC_RUN_CONTROL 4
`define RSWC_CTL_WATCHDOG_ENABLE_BIT 5
`define RSWC_CONTROL_CONFIG_REGISTER_PAB 3
`define RSWC_CMD_SLEEP 0
`define RSWC_CMD_WDTCLR 1
// Reset values and writable masks
`define RSWC_STATUS_RST 8'h18
`define RSWC_STATUS_WMSK 8'hE7
`define RSWC_CONTROL_CONFIG_REGISTER_RST 8'hBF
`define RSWC_CTL_RST 8'h31
`define RSWC_CTL_WMSK 8'h79
`define RSWC_INT_WMSK 8'h09
// Timing: start-up and watchdog base periods in ms, clock in kHz
`define RSWC_OST_MS 18
`define RSWC_WDT_MS 18
`define RSWC_CLK_KHZ 50000
`define RSWC_OST_CYC (`RSWC_OST_MS * `RSWC_CLK_KHZ)
`define RSWC_WDT_CYC (`RSWC_WDT_MS * `RSWC_CLK_KHZ)
`endif

// file: src/rswc_pkg.sv
// Types shared by the sequencer modules
package rswc_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    RSWC_RESET,
    RSWC_RUN,
    RSWC_SLEEP1,
    RSWC_SLEEP2,
    RSWC_WAKE
  } rswc_state_t;
endpackage

// file: src/rswc_timer.sv
// Start-up timer, watchdog counter and shared prescaler
`timescale 1ns/1ns
`include "rswc_cfg.svh"
module rswc_timer #(
  parameter int OST_CYC = `RSWC_OST_CYC,
  parameter int WDT_CYC = `RSWC_WDT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  rswc_tmr_if.tmr tif
);
  localparam int OW = $clog2(OST_CYC + 1);
  localparam int WW = $clog2(WDT_CYC + 1);

  // Counts too short for the state machine to see are refused
  if (OST_CYC < 2 || WDT_CYC < 2) begin : g_bad
    $error("rswc_timer: periods must be at least 2 cycles");
  end

  logic [OW-1:0] ost_reg, ost_next; // Start-up period counter
  logic busy_reg, busy_next; // Start-up running
  logic [WW-1:0] wdt_reg, wdt_next; // Watchdog base counter
  logic [7:0] pre_reg, pre_next; // Shared prescaler
  logic to_reg, to_next; // Time-out pulse
  logic [7:0] pre_lim; // Last prescaler count before time-out

  assign tif.ost_busy = busy_reg;
  assign tif.wdt_timeout = to_reg;

  // Next values of both timers
  always_comb begin
    ost_next = ost_reg;
    busy_next = busy_reg;
    wdt_next = wdt_reg;
    pre_next = pre_reg;
    to_next = 1'b0;
    pre_lim = 8'(({1'b0, 8'h01} << tif.pre_ratio) - 9'h001);
    // Start-up timer restarts on any wake-up or reset
    if (tif.ost_start) begin
      ost_next = '0;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (ost_reg == OW'(OST_CYC - 1)) begin
        busy_next = 1'b0;
      end else begin
        ost_next = ost_reg + 1'b1;
      end
    end
    // Watchdog keeps running through sleep; clear wins over counting
    if (tif.wdt_clr || !tif.wdt_en) begin
      wdt_next = '0;
      pre_next = 8'h00;
    end else if (wdt_reg == WW'(WDT_CYC - 1)) begin
      wdt_next = '0;
      // Without the prescaler every base period times out
      if (!tif.pre_wdt || pre_reg == pre_lim) begin
        pre_next = 8'h00;
        to_next = 1'b1;
      end else begin
        pre_next = pre_reg + 8'h01;
      end
    end else begin
      wdt_next = wdt_reg + 1'b1;
    end
  end

  // Register the timers; power-on starts the start-up period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_reg <= '0;
      busy_reg <= 1'b1;
      wdt_reg <= '0;
      pre_reg <= 8'h00;
      to_reg <= 1'b0;
    end else begin
      ost_reg <= ost_next;
      busy_reg <= busy_next;
      wdt_reg <= wdt_next;
      pre_reg <= pre_next;
      to_reg <= to_next;
    end
  end
endmodule

// file: src/rswc_tmr_if.sv
// Carrier between the sequencer and its start-up and watchdog timer
`timescale 1ns/1ns
interface rswc_tmr_if;
  logic ost_start; // Restart the start-up timer
  logic ost_busy; // Start-up period still running
  logic wdt_clr; // Clear watchdog and prescaler
  logic wdt_en; // Watchdog effectively enabled
  logic pre_wdt; // Prescaler assigned to watchdog
  logic [2:0] pre_ratio; // Watchdog prescale select
  logic wdt_timeout; // One-cycle time-out pulse
  modport ctl (output ost_start, output wdt_clr, output wdt_en, output pre_wdt,
    output pre_ratio, input ost_busy, input wdt_timeout);
  modport tmr (input ost_start, input wdt_clr, input wdt_en, input pre_wdt,
    input pre_ratio, output ost_busy, output wdt_timeout);
endinterface

// file: src/rswc_top.sv
// Reset, sleep and wake-up sequencer with its APB register file
`timescale 1ns/1ns
`include "rswc_cfg.svh"
module rswc_top import rswc_pkg::*; #(
  parameter int PC_W = 12,
  parameter int OST_CYC = `RSWC_OST_CYC,
  parameter int WDT_CYC = `RSWC_WDT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_reset_n,
  input wire logic [7:0] port6_wake_pins,
  input wire logic [1:0] port7_wake_pins,
  input wire logic watchdog_option_fuse,
  output logic core_reset,
  output logic core_stall,
  output logic osc_run,
  output logic [PC_W-1:0] program_counter,
  output logic [23:0] port_dir
);
  // Counter widths outside 1 to 16 bits are refused
  if (PC_W < 1 || PC_W > 16) begin : g_bad
    $error("rswc_top: PC_W must be 1 to 16");
  end

  rswc_tmr_if tif ();

  rswc_timer #(
    .OST_CYC(OST_CYC),
    .WDT_CYC(WDT_CYC)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif)
  );

  // Sequencer and register state
  rswc_state_t state_reg, state_next;
  logic [PC_W-1:0] pc_reg, pc_next; // program_counter
  logic [7:0] status_reg, status_next; // status_register
  logic [7:0] bank_reg, bank_next; // bank_select_register
  logic [7:0] control_config_register_reg, control_config_register_next; // control_config_register
  logic [7:0] wmask_reg, wmask_next; // port6_wake_mask, one disables
  logic [7:0] ctl_reg, ctl_next; // wdt_sleep_control
  logic [7:0] iflag_reg, iflag_next; // interrupt_flag_register
  logic [7:0] imask_reg, imask_next; // interrupt_mask_register
  logic [23:0] dir_reg, dir_next; // Port 7,6,5 directions, one is input
  logic rst_reg, rst_next; // Core held in reset
  logic stall_reg, stall_next; // Core not executing
  logic osc_reg, osc_next; // Oscillator running

  // APB state
  logic [31:0] rdata_reg, rdata_next;
  logic ready_reg, ready_next;
  logic err_reg, err_next;

  // Decoded helpers
  logic setup; // APB setup cycle
  logic wr; // Write taken at this edge
  logic hit; // Address is mapped
  logic [31:0] rd_mux; // Read value by address
  logic wdt_on; // Watchdog effective enable
  logic pin_wake; // Enabled wake pin low
  logic warm_rst; // Pin or time-out reset
  logic cmd_sleep; // Sleep instruction issued
  logic cmd_wdtclr; // Watchdog clear issued

  assign setup = psel && !penable;
  assign wr = psel && penable && ready_reg && pwrite;
  assign cmd_sleep = wr && paddr == `RSWC_A_CMD && pwdata[`RSWC_CMD_SLEEP];
  assign cmd_wdtclr = wr && paddr == `RSWC_A_CMD && pwdata[`RSWC_CMD_WDTCLR];
  // Fuse at one keeps the watchdog off whatever software writes
  assign wdt_on = !watchdog_option_fuse && ctl_reg[`RSWC_CTL_WATCHDOG_ENABLE_BIT];
  // Wake-up enables are active low; a pin wakes while it is low
  assign pin_wake = |(~port6_wake_pins & ~wmask_reg) ||
    (|(~port7_wake_pins) && !ctl_reg[`RSWC_CTL_WUE7]);
  // Reset causes other than power-on, which is presetn itself
  assign warm_rst = !ext_reset_n || (tif.wdt_timeout && wdt_on);

  assign tif.wdt_en = wdt_on;
  assign tif.pre_wdt = control_config_register_reg[`RSWC_CONTROL_CONFIG_REGISTER_PAB];
  assign tif.pre_ratio = control_config_register_reg[2:0];

  assign prdata = rdata_reg;
  assign pready = ready_reg;
  assign pslverr = err_reg;
  assign core_reset = rst_reg;
  assign core_stall = stall_reg;
  assign osc_run = osc_reg;
  assign program_counter = pc_reg;
  assign port_dir = dir_reg;

  // Read multiplexer; unused bits read as zero
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `RSWC_A_PC: rd_mux[PC_W-1:0] = pc_reg;
      `RSWC_A_STATUS: rd_mux[7:0] = status_reg;
      `RSWC_A_BANK: rd_mux[7:0] = bank_reg;
      `RSWC_A_CONTROL_CONFIG_REGISTER: rd_mux[7:0] = control_config_register_reg;
      `RSWC_A_WMASK: rd_mux[7:0] = wmask_reg;
      `RSWC_A_CTL: rd_mux[7:0] = ctl_reg;
      `RSWC_A_IFLAG: rd_mux[7:0] = iflag_reg;
      `RSWC_A_IMASK: rd_mux[7:0] = imask_reg;
      `RSWC_A_DIR: rd_mux[23:0] = dir_reg;
      `RSWC_A_CMD: rd_mux = 32'h0000_0000;
      `RSWC_A_STATE: rd_mux[2:0] = state_reg;
      default: hit = 1'b0;
    endcase
  end

  // APB answer: ready in the cycle after setup, so no wait states
  always_comb begin
    ready_next = setup;
    err_next = setup && !hit;
    rdata_next = setup ? rd_mux : rdata_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      err_reg <= err_next;
    end
  end

  // Sequencer: software writes first, then hardware events, so a set
  // always wins over a write in the same cycle
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    status_next = status_reg;
    bank_next = bank_reg;
    control_config_register_next = control_config_register_reg;
    wmask_next = wmask_reg;
    ctl_next = ctl_reg;
    iflag_next = iflag_reg;
    imask_next = imask_reg;
    dir_next = dir_reg;
    tif.ost_start = 1'b0;
    tif.wdt_clr = cmd_wdtclr;
    // Register writes; flags T and P are read-only
    if (wr) begin
      case (paddr)
        `RSWC_A_STATUS: status_next = (status_reg & ~`RSWC_STATUS_WMSK) |
          (pwdata[7:0] & `RSWC_STATUS_WMSK);
        `RSWC_A_BANK: bank_next = pwdata[7:0];
        `RSWC_A_CONTROL_CONFIG_REGISTER: control_config_register_next = pwdata[7:0];
        `RSWC_A_WMASK: wmask_next = pwdata[7:0];
        `RSWC_A_CTL: ctl_next = pwdata[7:0] & `RSWC_CTL_WMSK;
        `RSWC_A_IFLAG: iflag_next = pwdata[7:0] & `RSWC_INT_WMSK;
        `RSWC_A_IMASK: imask_next = pwdata[7:0] & `RSWC_INT_WMSK;
        `RSWC_A_DIR: dir_next = pwdata[23:0];
        default: ;
      endcase
    end
    // A watchdog clear also sets both flags back
    if (cmd_wdtclr) begin
      status_next[`RSWC_ST_T] = 1'b1;
      status_next[`RSWC_ST_P] = 1'b1;
    end
    case (state_reg)
      // Start-up period after reset or wake-up
      RSWC_RESET, RSWC_WAKE: begin
        if (!tif.ost_busy) begin
          state_next = RSWC_RUN;
        end
      end
      RSWC_RUN: begin
        if (cmd_sleep) begin
          // Watchdog restarts from zero and keeps counting in sleep
          state_next = RSWC_SLEEP1;
          tif.wdt_clr = 1'b1;
          status_next[`RSWC_ST_T] = 1'b1;
          status_next[`RSWC_ST_P] = 1'b0;
        end else if (!ctl_next[`RSWC_CTL_OSC_RUN_CONTROL]) begin
          state_next = RSWC_SLEEP2;
        end
      end
      // Only the warm reset below leaves this state
      RSWC_SLEEP1: state_next = RSWC_SLEEP1;
      RSWC_SLEEP2: begin
        if (pin_wake) begin
          ctl_next[`RSWC_CTL_OSC_RUN_CONTROL] = 1'b1;
          // Fuse at zero turns the watchdog back on after waking
          if (!watchdog_option_fuse) begin
            ctl_next[`RSWC_CTL_WATCHDOG_ENABLE_BIT] = 1'b1;
          end
          state_next = RSWC_WAKE;
          tif.ost_start = 1'b1;
          status_next[`RSWC_ST_T] = 1'b1;
          status_next[`RSWC_ST_P] = 1'b0;
        end
      end
      default: state_next = RSWC_RESET;
    endcase
    // Pin or time-out reset overrides everything else, in any state
    if (warm_rst) begin
      state_next = RSWC_RESET;
      tif.ost_start = 1'b1;
      tif.wdt_clr = 1'b1;
      pc_next = '1;
      // Status bits 6:5 and 2:0 and the whole bank survive this reset
      status_next[7] = 1'b0;
      // A pin held low keeps the cause seen on the first reset cycle
      if (state_reg != RSWC_RESET) begin
        status_next[`RSWC_ST_T] = !(tif.wdt_timeout && wdt_on);
        status_next[`RSWC_ST_P] = !(state_reg == RSWC_SLEEP1 ||
          state_reg == RSWC_SLEEP2);
      end
      bank_next = bank_reg;
      // The interrupt-enable flag in bit 6 keeps its value
      control_config_register_next = `RSWC_CONTROL_CONFIG_REGISTER_RST | (control_config_register_reg & 8'h40);
      wmask_next = 8'hFF;
      ctl_next = `RSWC_CTL_RST;
      iflag_next = iflag_reg & ~`RSWC_INT_WMSK;
      imask_next = imask_reg & ~`RSWC_INT_WMSK;
      dir_next = 24'hFF_FFFF;
    end
    // Outputs follow the next state so they change with it
    rst_next = state_next == RSWC_RESET;
    stall_next = state_next != RSWC_RUN;
    osc_next = !(state_next == RSWC_SLEEP1 || state_next == RSWC_SLEEP2);
  end

  // Power-on: every register takes its full reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= RSWC_RESET;
      pc_reg <= '1;
      status_reg <= `RSWC_STATUS_RST;
      bank_reg <= 8'h00;
      control_config_register_reg <= `RSWC_CONTROL_CONFIG_REGISTER_RST;
      wmask_reg <= 8'hFF;
      ctl_reg <= `RSWC_CTL_RST;
      iflag_reg <= 8'h00;
      imask_reg <= 8'h00;
      dir_reg <= 24'hFF_FFFF;
      rst_reg <= 1'b1;
      stall_reg <= 1'b1;
      osc_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      status_reg <= status_next;
      bank_reg <= bank_next;
      control_config_register_reg <= control_config_register_next;
      wmask_reg <= wmask_next;
      ctl_reg <= ctl_next;
      iflag_reg <= iflag_next;
      imask_reg <= imask_next;
      dir_reg <= dir_next;
      rst_reg <= rst_next;
      stall_reg <= stall_next;
      osc_reg <= osc_next;
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  warm_reset_a: assert property (warm_rst |=> core_reset && !osc_run == 1'b0)
    else $error("warm reset did not hold the core");
  pc_ones_a: assert property (warm_rst |=> program_counter == '1)
    else $error("program counter not all ones after reset");
  bank_keep_a: assert property (warm_rst |=> bank_reg == $past(bank_reg) &&
    status_reg[6:5] == $past(status_reg[6:5]))
    else $error("warm reset changed power-on-only bits");
  dir_input_a: assert property (warm_rst |=> port_dir == 24'hFF_FFFF)
    else $error("ports not inputs after reset");
  ctl_reset_a: assert property (warm_rst |=> ctl_reg == `RSWC_CTL_RST &&
    wmask_reg == 8'hFF && control_config_register_reg[5:0] == 6'h3F)
    else $error("control registers wrong after reset");
  ost_hold_a: assert property (tif.ost_start |=> tif.ost_busy [*8])
    else $error("start-up period ended too early");
  sleep_clear_a: assert property (state_reg == RSWC_RUN && cmd_sleep && !warm_rst
    |-> tif.wdt_clr ##1 state_reg == RSWC_SLEEP1 && !osc_run)
    else $error("sleep instruction mishandled");
  sleep1_stay_a: assert property (state_reg == RSWC_SLEEP1 && !warm_rst
    |=> state_reg == RSWC_SLEEP1)
    else $error("first sleep left without reset");
  wake_resume_a: assert property (state_reg == RSWC_SLEEP2 && pin_wake && !warm_rst
    |=> !core_reset && osc_run && ctl_reg[`RSWC_CTL_OSC_RUN_CONTROL] && pc_reg == $past(pc_reg))
    else $error("pin wake did not resume");
  fuse_off_a: assert property (watchdog_option_fuse |-> !tif.wdt_en)
    else $error("watchdog ran with fuse set");

  wake_c: cover property (state_reg == RSWC_SLEEP2 ##1 state_reg == RSWC_WAKE);
  sleep1_rst_c: cover property (state_reg == RSWC_SLEEP1 ##1 state_reg == RSWC_RESET);
  timeout_c: cover property (tif.wdt_timeout && wdt_on);
endmodule

// file: testbench/reset_sleep_wake_control_tb.sv
// Self-checking bench for the reset, sleep and wake-up sequencer
`timescale 1ns/1ns
`include "rswc_cfg.svh"
module reset_sleep_wake_control_tb import rswc_pkg::*; ;
  localparam int OSC_STARTUP_TIMER = 40; // Short start-up period for simulation
  localparam int WDT = 30; // Short watchdog base period
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic fuse = 1'b1; // Watchdog kept off unless a test wants it
  wire logic [31:0] prdata;
  wire logic pready, pslverr, ext_reset_n, core_reset, core_stall, osc_run;
  wire logic [7:0] p6;
  wire logic [1:0] p7;
  wire logic [11:0] pc;
  wire logic [23:0] dir;
  int fail_count = 0;
  int n_checks = 0;
  int mdl[9]; // Register model, indexed by word address
  int wm[9] = '{0, 'hE7, 'hFF, 'hFF, 'hFF, 'h79, 'h09, 'h09, 'hFFFFFF}; // Writable bits
  logic [31:0] rd;
  logic er, rst_seen, watch;
  int n, pick;
  // Clock at 50 MHz
  always #10 pclk = ~pclk;
  rswc_top #(.PC_W(12), .OST_CYC(OSC_STARTUP_TIMER), .WDT_CYC(WDT)) i_dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_reset_n(ext_reset_n),
    .port6_wake_pins(p6), .port7_wake_pins(p7), .watchdog_option_fuse(fuse),
    .core_reset(core_reset), .core_stall(core_stall), .osc_run(osc_run),
    .program_counter(pc), .port_dir(dir));
  rswc_partner i_part (.pclk(pclk), .ext_reset_n(ext_reset_n), .port6_wake_pins(p6),
    .port7_wake_pins(p7));
  // Flags any core reset while a pin wake is expected to resume quietly
  always @(posedge pclk) begin
    if (watch && core_reset !== 1'b0) begin
      rst_seen <= 1'b1;
    end
  end
  // Counts results and prints the verdict
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Case-equality compare; an unknown never matches
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write and mirror the writable bits into the model
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
    if (a <= `RSWC_A_DIR) begin
      mdl[a>>2] = (mdl[a>>2] & ~wm[a>>2]) | (d & wm[a>>2]);
    end
  endtask
  // Read one register and compare under a mask
  task automatic rreg(input int i, input logic [31:0] m);
    apb(1'b0, 8'(i * 4), 32'h0);
    chk($sformatf("reg%0d", i), mdl[i] & m, rd & m);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask
  // Read every modelled register
  task automatic regs();
    for (int i = 0; i < 9; i++) begin
      rreg(i, 32'hFFFFFFFF);
    end
  endtask
  // Compare the state register
  task automatic state_is(input rswc_state_t s);
    apb(1'b0, `RSWC_A_STATE, 32'h0);
    chk("state", 32'(s), rd);
  endtask
  // Count edges until the core runs again, bounded
  task automatic wait_run(output int c);
    c = 0;
    while (core_stall !== 1'b0 && c < 500) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 500) begin
      fail_count++;
      print_verdict();
    end
  endtask
  // Model of a warm reset: t and p are the recorded cause flags
  function automatic void mdl_warm(input int t, input int p);
    mdl[0] = 'hFFF;
    mdl[1] = (mdl[1] & 'h67) | (t << 4) | (p << 3);
    mdl[3] = 'hBF | (mdl[3] & 'h40);
    mdl[4] = 'hFF;
    mdl[5] = 'h31;
    mdl[6] = 0;
    mdl[7] = 0;
    mdl[8] = 'hFFFFFF;
  endfunction
  // Warm reset by pin, then full register compare
  task automatic pin_reset(input int t, input int p);
    i_part.hold_reset(3);
    mdl_warm(t, p);
    wait_run(n);
    chk("startup", 32'h1, 32'(n >= OSC_STARTUP_TIMER && n <= OSC_STARTUP_TIMER + 4));
    regs();
    chk("dir", 32'hFFFFFF, 32'(dir));
  endtask
  // Main sequence
  initial begin
    watch = 1'b0;
    rst_seen = 1'b0;
    void'($urandom(32'h7c77));
    mdl = '{'hFFF, 'h18, 0, 'hBF, 'hFF, 'h31, 0, 0, 'hFFFFFF};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_run(n);
    chk("por_startup", 32'h1, 32'(n >= OSC_STARTUP_TIMER && n <= OSC_STARTUP_TIMER + 4));
    for (int i = 0; i < 9; i++) begin
      rreg(i, i == 1 ? 32'hF8 : (i == 2 ? 32'hC0 : 32'hFFFFFFFF));
    end
    chk("pc", 32'hFFF, 32'(pc));
    chk("dir", 32'hFFFFFF, 32'(dir));
    state_is(RSWC_RUN);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    wr(`RSWC_A_PC, 0);
    wr(`RSWC_A_STATUS, 'h60);
    wr(`RSWC_A_BANK, 'hC5);
    wr(`RSWC_A_CONTROL_CONFIG_REGISTER, 'hFF);
    wr(`RSWC_A_WMASK, 'h00);
    wr(`RSWC_A_CTL, 'h58);
    wr(`RSWC_A_IFLAG, 'h09);
    wr(`RSWC_A_IMASK, 'h09);
    wr(`RSWC_A_DIR, 0);
    regs();
    pin_reset(1, 1);
    // First sleep: pins cannot wake it, only a reset leaves it
    wr(`RSWC_A_WMASK, 'hFE);
    apb(1'b1, `RSWC_A_CMD, 32'h1);
    mdl[1] = (mdl[1] & ~'h18) | 'h10;
    state_is(RSWC_SLEEP1);
    chk("osc_sleep1", 32'h0, {31'h0, osc_run});
    i_part.pull_pin(1'b0, 0);
    state_is(RSWC_SLEEP1);
    pin_reset(1, 0);
    // Second sleep, woken by a random enabled port-6 pin, then a port-7 pin
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      fuse <= 1'b0;
      pick = (k == 0) ? $urandom % 8 : $urandom % 2;
      apb(1'b1, `RSWC_A_CMD, 32'h2);
      mdl[1] = mdl[1] | 'h18;
      wr(`RSWC_A_WMASK, k == 0 ? (~(1 << pick)) & 'hFF : 'hFF);
      wr(`RSWC_A_CTL, k == 0 ? 'h01 : 'h00);
      state_is(RSWC_SLEEP2);
      chk("osc_sleep2", 32'h0, {31'h0, osc_run});
      i_part.pull_pin(1'b0, k == 0 ? (pick + 1) % 8 : pick);
      state_is(RSWC_SLEEP2);
      watch = 1'b1;
      rst_seen = 1'b0;
      i_part.pull_pin(k == 1, pick);
      wait_run(n);
      watch = 1'b0;
      chk("no_reset", 32'h0, {31'h0, rst_seen});
      chk("wake_ost", 32'h1, 32'(n + 3 >= OSC_STARTUP_TIMER && n + 3 <= OSC_STARTUP_TIMER + 5));
      mdl[5] = mdl[5] | 'h30;
      mdl[1] = (mdl[1] & ~'h18) | 'h10;
      regs();
      // Software side after resume: wake-up off, watchdog off
      wr(`RSWC_A_WMASK, 'hFF);
      wr(`RSWC_A_CTL, 'h11);
    end
    // Watchdog ignored while the fuse is one, then a time-out resets
    @(posedge pclk);
    fuse <= 1'b1;
    wr(`RSWC_A_CONTROL_CONFIG_REGISTER, 'h00);
    wr(`RSWC_A_CTL, 'h30);
    apb(1'b1, `RSWC_A_CMD, 32'h2);
    mdl[1] = mdl[1] | 'h18;
    n = 0;
    repeat (3 * WDT) begin
      @(posedge pclk);
      n += (core_reset !== 1'b0);
    end
    chk("fuse_off", 32'h0, 32'(n));
    @(posedge pclk);
    fuse <= 1'b0;
    apb(1'b1, `RSWC_A_CMD, 32'h2);
    n = 0;
    while (core_reset !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("wdt_time", 32'h1, 32'(n >= WDT - 2 && n <= WDT + 3));
    mdl_warm(0, 1);
    wait_run(n);
    regs();
    print_verdict();
  end
endmodule

// file: testbench/rswc_partner.sv
// Model of the external reset source and the pulled-up wake-up pins
`timescale 1ns/1ns
module rswc_partner (
  input wire logic pclk,
  output logic ext_reset_n,
  output logic [7:0] port6_wake_pins,
  output logic [1:0] port7_wake_pins
);
  // Released lines sit at the pull-up level, pins are inputs only
  initial begin
    ext_reset_n = 1'b1;
    port6_wake_pins = 8'hFF;
    port7_wake_pins = 2'h3;
  end
  // Hold the reset pin low for n edges; changes just after an edge
  task automatic hold_reset(input int n);
    @(posedge pclk);
    ext_reset_n <= 1'b0;
    repeat (n) @(posedge pclk);
    ext_reset_n <= 1'b1;
  endtask
  // Pull one wake pin low for three edges, then let the pull-up win again
  task automatic pull_pin(input bit p7, input int i);
    @(posedge pclk);
    if (p7) begin
      port7_wake_pins[i] <= 1'b0;
    end else begin
      port6_wake_pins[i] <= 1'b0;
    end
    repeat (3) @(posedge pclk);
    port6_wake_pins <= 8'hFF;
    port7_wake_pins <= 2'h3;
  endtask
endmodule
